// ### rfs_net_model.sv
/*
  network side model: byte source for received frames, stalling sink.
  assumes the testbench calls send_frame just after a rising edge.
*/
`timescale 1ns/10ps
module rfs_net_model (
  input  wire logic       clk_in,
  output logic            rx_valid_out,
  output logic      [7:0] rx_data_out,
  output logic            rx_last_out,
  input  wire logic       rx_ready_in,
  input  wire logic       tx_valid_in,
  input  wire logic [7:0] tx_data_in,
  input  wire logic       tx_last_in,
  output logic            tx_ready_out
);
  logic [7:0]  tx_q[$];
  int unsigned cyc = 0;
  int unsigned tx_frames = 0;
  initial begin
    rx_valid_out = 1'b0;
    rx_data_out = 8'h00;
    rx_last_out = 1'b0;
    tx_ready_out = 1'b0;
  end
  // stall one cycle in three so the engine must hold its byte
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    tx_ready_out <= (cyc % 3) != 0;
    if (tx_valid_in && tx_ready_out) tx_q.push_back(tx_data_in);
    if (tx_valid_in && tx_ready_out && tx_last_in) tx_frames <= tx_frames + 1;
  end
  task automatic send_frame(input logic [7:0] q[$]);
    for (int i = 0; i < q.size(); i++) begin
      rx_valid_out <= 1'b1;
      rx_data_out <= q[i];
      rx_last_out <= (i == q.size() - 1);
      @(posedge clk_in);
      while (!rx_ready_in) @(posedge clk_in);
    end
    rx_valid_out <= 1'b0;
    rx_last_out <= 1'b0;
    // idle data inverted so a stale byte is never mistaken for fresh
    rx_data_out <= ~rx_data_out;
    repeat (5) @(posedge clk_in);
  endtask
endmodule

// ### rfs_pkg.sv
/*
  constants of the raw frame channel: register offsets, command and state
  codes, mode fields and frame figures.
  assumes a 32-bit AHB-Lite bus and a byte-wide network side.
*/
// Summary of operation
// - raw frame mode exists only on channel zero; other channels unaffected.
// - each received frame stored as length header, frame bytes, check bytes.
// - header counts frame bytes only, no header or check bytes.
// - frame holds destination, source, type, then 46 to 1500 payload bytes.
// - with too little free space only part of a record is stored.
// - filter bit set (mode 0x44, not 0x04) keeps only own and broadcast frames.
// - transmitted frames shorter than 60 bytes are zero padded to 60 bytes.
// - raw frame transmission never raises a timeout.
package rfs_pkg;
  localparam logic [7:0]  OFS_MODE       = 8'h00;
  localparam logic [7:0]  OFS_COMMAND    = 8'h04;
  localparam logic [7:0]  OFS_STATE      = 8'h08;
  localparam logic [7:0]  OFS_RX_WORD    = 8'h0C;
  localparam logic [7:0]  OFS_RX_LEN     = 8'h10;
  localparam logic [7:0]  OFS_RX_CFG     = 8'h14;
  localparam logic [7:0]  OFS_TX_WORD    = 8'h18;
  localparam logic [7:0]  OFS_TX_LEN     = 8'h1C;
  localparam logic [7:0]  OFS_TX_FREE    = 8'h20;
  localparam logic [7:0]  OFS_MAC_HI     = 8'h24;
  localparam logic [7:0]  OFS_MAC_LO     = 8'h28;
  localparam logic [7:0]  MODE_RESET     = 8'h00;
  localparam logic [3:0]  MODE_RAW_FRAME = 4'h4;
  localparam int unsigned MODE_FILTER_BIT = 6;
  localparam logic [7:0]  CMD_OPEN       = 8'h01;
  localparam logic [7:0]  CMD_CLOSE      = 8'h10;
  localparam logic [7:0]  CMD_SEND       = 8'h20;
  localparam logic [7:0]  CMD_RECEIVE_DONE = 8'h40;
  localparam logic [7:0]  STATE_SHUT     = 8'h00;
  localparam logic [7:0]  STATE_RAW_FRAME_OPEN = 8'h01;
  localparam logic [15:0] MIN_FRAME_BYTES = 16'h003C;
  localparam logic [15:0] DEST_ADDR_BYTES = 16'h0006;
  localparam logic [2:0]  CHECK_BYTES    = 3'h4;
  localparam logic [47:0] OWN_MAC_RESET  = 48'h0000_0000_0000;
  localparam int unsigned KB_BYTES       = 1024;
  localparam logic [1:0]  HTRANS_NONSEQ  = 2'h2;
  localparam logic [1:0]  HRESP_OKAY     = 2'h0;
endpackage

// ### rfs_raw_socket.sv
/*
  raw frame channel zero: AHB-Lite register slave, receive record writer,
  transmit engine with zero padding.
  assumes byte streams on the network side with valid/ready handshakes;
  the receive stream carries the four check bytes as its last bytes.
*/
// Decided for this implementation: the address map and the AHB-Lite slave port.
`timescale 1ns/10ps
module rfs_raw_socket
  import rfs_pkg::*;
#(
  parameter int unsigned RX_AW = 11,
  parameter int unsigned TX_AW = 11
)(
  input  wire logic        CLOCK_IN,
  input  wire logic        RST_B_IN,
  input  wire logic        HSEL_IN,
  input  wire logic [31:0] HADDR_IN,
  input  wire logic [1:0]  HTRANS_IN,
  input  wire logic        HWRITE_IN,
  input  wire logic [2:0]  HSIZE_IN,
  input  wire logic [31:0] HWDATA_IN,
  input  wire logic        HREADY_IN,
  output logic      [31:0] HRDATA_OUT,
  output logic             HREADYOUT_OUT,
  output logic      [1:0]  HRESP_OUT,
  input  wire logic        RX_VALID_IN,
  input  wire logic [7:0]  RX_DATA_IN,
  input  wire logic        RX_LAST_IN,
  output logic             RX_READY_OUT,
  output logic             TX_VALID_OUT,
  output logic      [7:0]  TX_DATA_OUT,
  output logic             TX_LAST_OUT,
  input  wire logic        TX_READY_IN
);
  localparam int unsigned RPW = RX_AW + 1;
  localparam int unsigned TPW = TX_AW + 1;
  localparam logic [31:0] RX_KB = 32'((2 ** RX_AW) * 2 / KB_BYTES);

  // buffers below 2 KB cannot hold a full frame record
  if (RX_AW < 10 || RX_AW > 15 || TX_AW < 10 || TX_AW > 15) begin : g_bad
    $error("rfs_raw_socket: address widths must lie in 10..15");
  end
  typedef enum logic [2:0] {
    RX_TAKE = 3'b000, RX_PAD = 3'b001, RX_CHK_HI = 3'b011,
    RX_CHK_LO = 3'b010, RX_HEADER = 3'b110
  } rfs_rx_state_t;
  typedef enum logic [2:0] {
    TX_IDLE = 3'b000, TX_FETCH = 3'b001, TX_LOAD = 3'b011,
    TX_SHOW = 3'b010, TX_DONE = 3'b110
  } rfs_tx_state_t;
  logic [7:0]     dp_addr_reg, mode_reg, rx_hi_reg, tx_byte_reg;
  logic           dp_wr_reg, dp_rx_read_reg, sock_open_reg;
  logic           rx_drop_reg, rx_own_reg, rx_bc_reg;
  logic [31:0]    hrdata_reg, rx_dly_reg;
  logic [47:0]    own_mac_reg;
  logic [15:0]    tx_len_reg, rx_fcnt_reg, tx_send_len_reg, tx_pos_reg;
  logic [RPW-1:0] rx_wp_reg, rx_cur_reg, rx_hdr_reg, rx_rp_reg, rx_rel_reg;
  logic [2:0]     rx_cnt_reg;
  rfs_rx_state_t  rx_state_reg;
  logic [TPW-1:0] tx_wp_reg, tx_rel_reg;
  rfs_tx_state_t  tx_state_reg;
  logic [15:0]    rx_rdata, tx_rdata;
  // bus decode
  wire ahb_take   = HSEL_IN & HTRANS_IN[1] & HREADY_IN;
  wire ahb_read   = ahb_take & ~HWRITE_IN;
  wire rx_rd_take = ahb_read & (HADDR_IN[7:0] == OFS_RX_WORD)
                    & (rx_rp_reg != rx_wp_reg);
  wire wr_mode    = dp_wr_reg & (dp_addr_reg == OFS_MODE);
  wire wr_cmd     = dp_wr_reg & (dp_addr_reg == OFS_COMMAND);
  wire wr_tx_word = dp_wr_reg & (dp_addr_reg == OFS_TX_WORD);
  wire [7:0] cmd  = HWDATA_IN[7:0];
  wire cmd_open   = wr_cmd & (cmd == CMD_OPEN);
  wire cmd_close  = wr_cmd & (cmd == CMD_CLOSE);
  wire cmd_send   = wr_cmd & (cmd == CMD_SEND);
  wire cmd_done   = wr_cmd & (cmd == CMD_RECEIVE_DONE);
  // space bookkeeping in words; the top pointer bit tells full from empty
  wire [RPW-1:0] rx_fill = rx_cur_reg - rx_rel_reg;
  wire [RPW-1:0] rx_used = rx_wp_reg - rx_rel_reg;
  wire           rx_room = ~rx_fill[RX_AW];
  wire [TPW-1:0] tx_fill = tx_wp_reg - tx_rel_reg;
  wire           tx_room = ~tx_fill[TX_AW];
  wire [TPW-1:0] tx_free = TPW'(2 ** TX_AW) - tx_fill;
  wire [31:0] rd_value =
    (HADDR_IN[7:0] == OFS_MODE)    ? {24'h0, mode_reg} :
    (HADDR_IN[7:0] == OFS_COMMAND) ? {31'h0, tx_state_reg != TX_IDLE} :
    (HADDR_IN[7:0] == OFS_STATE)   ?
      {24'h0, sock_open_reg ? STATE_RAW_FRAME_OPEN : STATE_SHUT} :
    (HADDR_IN[7:0] == OFS_RX_LEN)  ? 32'({rx_used, 1'b0}) :
    (HADDR_IN[7:0] == OFS_RX_CFG)  ? RX_KB :
    (HADDR_IN[7:0] == OFS_TX_LEN)  ? {16'h0, tx_len_reg} :
    (HADDR_IN[7:0] == OFS_TX_FREE) ? 32'({tx_free, 1'b0}) :
    (HADDR_IN[7:0] == OFS_MAC_HI)  ? {16'h0, own_mac_reg[47:32]} :
    (HADDR_IN[7:0] == OFS_MAC_LO)  ? own_mac_reg[31:0] :
    32'h0000_0000;
  assign HREADYOUT_OUT = 1'b1;
  assign HRESP_OUT     = HRESP_OKAY;
  // receive words come straight from the memory's output register
  assign HRDATA_OUT    = dp_rx_read_reg ? {16'h0, rx_rdata} : hrdata_reg;
  always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      dp_addr_reg    <= 8'h00;
      dp_wr_reg      <= 1'b0;
      dp_rx_read_reg <= 1'b0;
      hrdata_reg     <= 32'h0000_0000;
    end else begin
      dp_wr_reg      <= ahb_take & HWRITE_IN;
      dp_rx_read_reg <= ahb_read & (HADDR_IN[7:0] == OFS_RX_WORD);
      if (ahb_take) begin
        dp_addr_reg <= HADDR_IN[7:0];
      end
      if (ahb_read) begin
        hrdata_reg <= rd_value;
      end
    end
  end

  always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      mode_reg      <= MODE_RESET;
      sock_open_reg <= 1'b0;
      own_mac_reg   <= OWN_MAC_RESET;
      tx_len_reg    <= 16'h0000;
      rx_rp_reg     <= '0;
      rx_rel_reg    <= '0;
      tx_wp_reg     <= '0;
    end else begin
      if (wr_mode) mode_reg <= HWDATA_IN[7:0];
      // this block is channel zero; other channels never see this mode
      if (cmd_open && mode_reg[3:0] == MODE_RAW_FRAME) begin
        sock_open_reg <= 1'b1;
      end else if (cmd_close) begin
        sock_open_reg <= 1'b0;
      end
      if (dp_wr_reg && dp_addr_reg == OFS_MAC_HI)
        own_mac_reg[47:32] <= HWDATA_IN[15:0];
      if (dp_wr_reg && dp_addr_reg == OFS_MAC_LO)
        own_mac_reg[31:0] <= HWDATA_IN;
      if (dp_wr_reg && dp_addr_reg == OFS_TX_LEN)
        tx_len_reg <= HWDATA_IN[15:0];
      if (rx_rd_take) rx_rp_reg <= rx_rp_reg + 1'b1;
      if (cmd_done) rx_rel_reg <= rx_rp_reg;
      if (wr_tx_word && tx_room) tx_wp_reg <= tx_wp_reg + 1'b1;
    end
  end

  // receive record writer: four-byte delay separates frame from check bytes
  wire       rx_take   = RX_VALID_IN & (rx_state_reg == RX_TAKE);
  wire       rx_first  = rx_take & (rx_cnt_reg == 3'h0);
  wire       rx_fb_ok  = rx_take & (rx_cnt_reg == CHECK_BYTES);
  wire [7:0] rx_fb     = rx_dly_reg[31:24];
  wire [7:0] own_byte  =
    8'(own_mac_reg >> {3'h5 - rx_fcnt_reg[2:0], 3'h0});
  wire       rx_accept = ~rx_drop_reg & (~mode_reg[MODE_FILTER_BIT]
                         | rx_own_reg | rx_bc_reg);
  wire       hdr_w     = (rx_state_reg == RX_HEADER) & rx_accept;
  wire       data_w    = (rx_fb_ok & rx_fcnt_reg[0])
                         | ((rx_state_reg == RX_PAD) & rx_fcnt_reg[0])
                         | (rx_state_reg == RX_CHK_HI)
                         | (rx_state_reg == RX_CHK_LO);
  // a full buffer silently truncates the record, header stays true
  wire       rx_we     = ~rx_drop_reg & (hdr_w | (rx_room & data_w));
  wire [RX_AW-1:0] rx_waddr = hdr_w ? rx_hdr_reg[RX_AW-1:0]
                                    : rx_cur_reg[RX_AW-1:0];
  wire [15:0] rx_wdata =
    (rx_state_reg == RX_TAKE)   ? {rx_hi_reg, rx_fb} :
    (rx_state_reg == RX_PAD)    ? {rx_hi_reg, 8'h00} :
    (rx_state_reg == RX_CHK_HI) ? rx_dly_reg[31:16] :
    (rx_state_reg == RX_CHK_LO) ? rx_dly_reg[15:0] :
    rx_fcnt_reg;
  assign RX_READY_OUT = (rx_state_reg == RX_TAKE);
  always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      rx_state_reg <= RX_TAKE;
      rx_wp_reg    <= '0;
      rx_cur_reg   <= '0;
      rx_hdr_reg   <= '0;
      rx_cnt_reg   <= 3'h0;
      rx_fcnt_reg  <= 16'h0000;
      rx_dly_reg   <= 32'h0000_0000;
      rx_hi_reg    <= 8'h00;
      rx_drop_reg  <= 1'b0;
      rx_own_reg   <= 1'b1;
      rx_bc_reg    <= 1'b1;
    end else begin
      case (rx_state_reg)
        RX_TAKE: begin
          if (rx_take) begin
            rx_dly_reg <= {rx_dly_reg[23:0], RX_DATA_IN};
            if (rx_cnt_reg != CHECK_BYTES) rx_cnt_reg <= rx_cnt_reg + 1'b1;
            if (RX_LAST_IN) rx_state_reg <= RX_PAD;
          end
          // header slot is reserved ahead of the frame, filled at the end
          if (rx_first) begin
            rx_drop_reg <= ~(sock_open_reg & rx_room);
            rx_hdr_reg  <= rx_wp_reg;
            if (sock_open_reg && rx_room) begin
              rx_cur_reg <= rx_cur_reg + 1'b1;
            end
          end
          if (rx_fb_ok) begin
            rx_fcnt_reg <= rx_fcnt_reg + 1'b1;
            if (!rx_fcnt_reg[0]) rx_hi_reg <= rx_fb;
            if (rx_fcnt_reg < DEST_ADDR_BYTES) begin
              rx_own_reg <= rx_own_reg & (rx_fb == own_byte);
              rx_bc_reg  <= rx_bc_reg & (rx_fb == 8'hFF);
            end
          end
          if (rx_we) rx_cur_reg <= rx_cur_reg + 1'b1;
        end
        RX_PAD, RX_CHK_HI, RX_CHK_LO: begin
          if (rx_we) rx_cur_reg <= rx_cur_reg + 1'b1;
          rx_state_reg <= (rx_state_reg == RX_PAD)    ? RX_CHK_HI :
                          (rx_state_reg == RX_CHK_HI) ? RX_CHK_LO : RX_HEADER;
        end
        RX_HEADER: begin
          if (rx_accept) begin
            rx_wp_reg <= rx_cur_reg;
          end else begin
            rx_cur_reg <= rx_wp_reg;
          end
          rx_cnt_reg   <= 3'h0;
          rx_fcnt_reg  <= 16'h0000;
          rx_drop_reg  <= 1'b0;
          rx_own_reg   <= 1'b1;
          rx_bc_reg    <= 1'b1;
          rx_state_reg <= RX_TAKE;
        end
        default: begin
          rx_state_reg <= RX_TAKE;
        end
      endcase
    end
  end
  // transmit engine: one byte per fetch, padding bytes forced to zero
  wire [15:0] tx_total = (tx_send_len_reg < MIN_FRAME_BYTES)
                         ? MIN_FRAME_BYTES : tx_send_len_reg;
  wire tx_end = (tx_pos_reg == tx_total - 16'h0001);
  wire [TX_AW-1:0] tx_raddr =
    tx_rel_reg[TX_AW-1:0] + tx_pos_reg[TX_AW:1];
  wire [TPW-1:0] tx_words = TPW'((17'(tx_send_len_reg) + 17'h00001) >> 1);
  assign TX_VALID_OUT = (tx_state_reg == TX_SHOW);
  assign TX_DATA_OUT  = tx_byte_reg;
  assign TX_LAST_OUT  = (tx_state_reg == TX_SHOW) & tx_end;
  always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      tx_state_reg    <= TX_IDLE;
      tx_rel_reg      <= '0;
      tx_send_len_reg <= 16'h0000;
      tx_pos_reg      <= 16'h0000;
      tx_byte_reg     <= 8'h00;
    end else begin
      case (tx_state_reg)
        TX_IDLE: begin
          if (cmd_send && sock_open_reg && tx_len_reg != 16'h0000) begin
            tx_send_len_reg <= tx_len_reg;
            tx_pos_reg      <= 16'h0000;
            tx_state_reg    <= TX_FETCH;
          end
        end
        TX_FETCH: begin
          tx_state_reg <= TX_LOAD;
        end
        TX_LOAD: begin
          tx_byte_reg  <= (tx_pos_reg >= tx_send_len_reg) ? 8'h00 :
                          tx_pos_reg[0] ? tx_rdata[7:0] : tx_rdata[15:8];
          tx_state_reg <= TX_SHOW;
        end
        TX_SHOW: begin
          if (TX_READY_IN) begin
            tx_pos_reg   <= tx_pos_reg + 16'h0001;
            tx_state_reg <= tx_end ? TX_DONE : TX_FETCH;
          end
        end
        TX_DONE: begin
          // no timer: the host owns every protocol timeout here
          tx_rel_reg   <= tx_rel_reg + tx_words;
          tx_state_reg <= TX_IDLE;
        end
        default: begin
          tx_state_reg <= TX_IDLE;
        end
      endcase
    end
  end
  rfs_word_ram #(.DW(16), .AW(RX_AW)) u_rx_ram (
    .clk_in(CLOCK_IN), .rst_b_in(RST_B_IN), .we_in(rx_we),
    .waddr_in(rx_waddr), .wdata_in(rx_wdata),
    .raddr_in(rx_rp_reg[RX_AW-1:0]), .rdata_out(rx_rdata));
  rfs_word_ram #(.DW(16), .AW(TX_AW)) u_tx_ram (
    .clk_in(CLOCK_IN), .rst_b_in(RST_B_IN), .we_in(wr_tx_word & tx_room),
    .waddr_in(tx_wp_reg[TX_AW-1:0]), .wdata_in(HWDATA_IN[15:0]),
    .raddr_in(tx_raddr), .rdata_out(tx_rdata));
endmodule

// ### rfs_raw_socket_sva.sv
/*
  port checker for the raw frame channel, bound into rfs_raw_socket.
  assumes one clock, hready looped back and tx length set before send.
*/
`timescale 1ns/10ps
module rfs_raw_socket_chk
  import rfs_pkg::*;
#(
  parameter int unsigned RX_AW = 11
)(
  input wire logic        CLOCK_IN,
  input wire logic        RST_B_IN,
  input wire logic        HSEL_IN,
  input wire logic [31:0] HADDR_IN,
  input wire logic [1:0]  HTRANS_IN,
  input wire logic        HWRITE_IN,
  input wire logic [31:0] HWDATA_IN,
  input wire logic        HREADY_IN,
  input wire logic [31:0] HRDATA_OUT,
  input wire logic        HREADYOUT_OUT,
  input wire logic [1:0]  HRESP_OUT,
  input wire logic        TX_VALID_OUT,
  input wire logic [7:0]  TX_DATA_OUT,
  input wire logic        TX_LAST_OUT,
  input wire logic        TX_READY_IN,
  input wire logic        RX_VALID_IN,
  input wire logic        RX_LAST_IN,
  input wire logic        RX_READY_OUT
);
  localparam int unsigned RX_KB = (2 ** RX_AW) * 2 / KB_BYTES;
  logic        dp_wr_reg;
  logic [7:0]  dp_addr_reg;
  logic [15:0] len_reg;
  logic [15:0] cnt_reg;
  wire         take_w = HSEL_IN && HTRANS_IN[1] && HREADY_IN;
  wire         rd_w   = take_w && !HWRITE_IN;
  wire  [7:0]  ra_w   = HADDR_IN[7:0];
  wire         short_w = len_reg < MIN_FRAME_BYTES;
  wire  [15:0] last_w = (short_w ? MIN_FRAME_BYTES : len_reg) - 16'h0001;
  default clocking @(posedge CLOCK_IN); endclocking
  default disable iff (!RST_B_IN);
  // length is tracked from the bus, so a length rewrite mid-frame is followed here while the engine keeps the length it latched at send
  always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      dp_wr_reg <= 1'b0;
      dp_addr_reg <= 8'h00;
      len_reg <= 16'h0000;
    end else begin
      dp_wr_reg <= take_w && HWRITE_IN;
      dp_addr_reg <= ra_w;
      if (dp_wr_reg && dp_addr_reg == OFS_TX_LEN) len_reg <= HWDATA_IN[15:0];
    end
  end
  always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) cnt_reg <= 16'h0000;
    else if (TX_VALID_OUT && TX_READY_IN)
      cnt_reg <= TX_LAST_OUT ? 16'h0000 : cnt_reg + 16'h0001;
  end
  property p_okay;
    HREADYOUT_OUT && HRESP_OUT == HRESP_OKAY;
  endproperty
  a_okay: assert property (p_okay)
    else $error("bus stalled or errored");
  property p_tx_hold;
    TX_VALID_OUT && !TX_READY_IN |=>
      TX_VALID_OUT && $stable(TX_DATA_OUT) && $stable(TX_LAST_OUT);
  endproperty
  a_tx_hold: assert property (p_tx_hold)
    else $error("tx byte dropped while stalled");
  property p_tx_gap;
    TX_VALID_OUT && TX_READY_IN && !TX_LAST_OUT |=>
      !TX_VALID_OUT [*2] ##1 TX_VALID_OUT;
  endproperty
  a_tx_gap: assert property (p_tx_gap)
    else $error("tx byte spacing wrong");
  property p_pad_zero;
    TX_VALID_OUT && cnt_reg >= len_reg |-> TX_DATA_OUT == 8'h00;
  endproperty
  a_pad_zero: assert property (p_pad_zero)
    else $error("pad byte not zero");
  property p_last_count;
    TX_VALID_OUT && TX_LAST_OUT |-> cnt_reg == last_w;
  endproperty
  a_last_count: assert property (p_last_count)
    else $error("tx frame length wrong");
  property p_rx_word;
    rd_w && ra_w == OFS_RX_WORD |=> HRDATA_OUT[31:16] == 16'h0000;
  endproperty
  a_rx_word: assert property (p_rx_word)
    else $error("rx port wider than a word");
  property p_cfg;
    rd_w && ra_w == OFS_RX_CFG |=> HRDATA_OUT == 32'(RX_KB);
  endproperty
  a_cfg: assert property (p_cfg)
    else $error("rx size in kilobytes wrong");
  property p_rx_even;
    rd_w && ra_w == OFS_RX_LEN |=> HRDATA_OUT[0] == 1'b0;
  endproperty
  a_rx_even: assert property (p_rx_even)
    else $error("received length not whole words");
  property p_state;
    rd_w && ra_w == OFS_STATE |=> HRDATA_OUT[31:1] == 31'h0;
  endproperty
  a_state: assert property (p_state)
    else $error("unknown channel state");
  property p_rx_gap;
    RX_VALID_IN && RX_READY_OUT && RX_LAST_IN |=>
      !RX_READY_OUT [*4] ##1 RX_READY_OUT;
  endproperty
  a_rx_gap: assert property (p_rx_gap)
    else $error("rx record close timing wrong");
endmodule
bind rfs_raw_socket rfs_raw_socket_chk #(.RX_AW(RX_AW)) u_chk (
  .CLOCK_IN      (CLOCK_IN),
  .RST_B_IN      (RST_B_IN),
  .HSEL_IN       (HSEL_IN),
  .HADDR_IN      (HADDR_IN),
  .HTRANS_IN     (HTRANS_IN),
  .HWRITE_IN     (HWRITE_IN),
  .HWDATA_IN     (HWDATA_IN),
  .HREADY_IN     (HREADY_IN),
  .HRDATA_OUT    (HRDATA_OUT),
  .HREADYOUT_OUT (HREADYOUT_OUT),
  .HRESP_OUT     (HRESP_OUT),
  .TX_VALID_OUT  (TX_VALID_OUT),
  .TX_DATA_OUT   (TX_DATA_OUT),
  .TX_LAST_OUT   (TX_LAST_OUT),
  .TX_READY_IN   (TX_READY_IN),
  .RX_VALID_IN   (RX_VALID_IN),
  .RX_LAST_IN    (RX_LAST_IN),
  .RX_READY_OUT  (RX_READY_OUT)
);

// ### rfs_word_ram.sv
/*
  simple dual-port word memory with registered read data.
  assumes one writer and one reader, both on the same clock.
*/
`timescale 1ns/10ps
module rfs_word_ram #(
  parameter int unsigned DW = 16,
  parameter int unsigned AW = 11
)(
  input  wire logic          clk_in,
  input  wire logic          rst_b_in,
  input  wire logic          we_in,
  input  wire logic [AW-1:0] waddr_in,
  input  wire logic [DW-1:0] wdata_in,
  input  wire logic [AW-1:0] raddr_in,
  output logic      [DW-1:0] rdata_out
);
  logic [DW-1:0] mem_array [0:(1<<AW)-1];

  // no reset on the array: contents are only meaningful once written
  always_ff @(posedge clk_in) begin
    if (we_in) begin
      mem_array[waddr_in] <= wdata_in;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rdata_out <= '0;
    end else begin
      rdata_out <= mem_array[raddr_in];
    end
  end
endmodule

// ### tb_top.sv
/*
  testbench for rfs_raw_socket: AHB-Lite host tasks and network model.
  assumes zero wait states are not relied on; waits poll hready.
*/
`timescale 1ns/10ps
module tb_top;
  import rfs_pkg::*;
  localparam logic [47:0] OWN_MAC   = 48'h02A0_B1C2_D3E4;
  localparam logic [47:0] OTHER_MAC = 48'h0633_4455_6677;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [1:0]  hresp;
  wire         hready;
  wire         rx_valid, rx_last, rx_ready, tx_valid, tx_last, tx_ready;
  wire  [7:0]  rx_data, tx_data;
  int          error_cnt = 0;
  int          checks_done = 0;
  logic [7:0]  fr[$];
  always #12.5 clk = ~clk;
  rfs_raw_socket dut (
    .CLOCK_IN(clk), .RST_B_IN(rst_b), .HSEL_IN(hsel), .HADDR_IN(haddr),
    .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(3'h2),
    .HWDATA_IN(hwdata), .HREADY_IN(hready), .HRDATA_OUT(hrdata),
    .HREADYOUT_OUT(hready), .HRESP_OUT(hresp), .RX_VALID_IN(rx_valid),
    .RX_DATA_IN(rx_data), .RX_LAST_IN(rx_last), .RX_READY_OUT(rx_ready),
    .TX_VALID_OUT(tx_valid), .TX_DATA_OUT(tx_data), .TX_LAST_OUT(tx_last),
    .TX_READY_IN(tx_ready));
  rfs_net_model net (
    .clk_in(clk), .rx_valid_out(rx_valid), .rx_data_out(rx_data),
    .rx_last_out(rx_last), .rx_ready_in(rx_ready), .tx_valid_in(tx_valid),
    .tx_data_in(tx_data), .tx_last_in(tx_last), .tx_ready_out(tx_ready));
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string msg);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= {24'h000000, a};
    hwrite <= wr;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
                        input string msg);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    chk(x, e, msg);
  endtask
  task automatic open_raw(input logic [7:0] m);
    wr(OFS_MODE, {24'h0, m});
    wr(OFS_COMMAND, {24'h0, CMD_OPEN});
    @(posedge clk);
    rd_chk(OFS_STATE, {24'h0, STATE_RAW_FRAME_OPEN}, "open");
  endtask
  task automatic mk(input logic [47:0] dst, input int n);
    fr.delete();
    for (int i = 0; i < n; i++) fr.push_back(i < 6 ? dst[47-8*i -: 8] : 8'(i));
    for (int i = 0; i < 4; i++) fr.push_back(8'hC0 + 8'(i));
    net.send_frame(fr);
  endtask
  task automatic drain(input int n);
    logic [31:0] x;
    rd_chk(OFS_RX_WORD, 32'(n), "header");
    for (int i = 0; i < (n + 1) / 2; i++) begin
      x = {16'h0, fr[2*i], (2 * i + 1 < n) ? fr[2*i+1] : 8'h00};
      rd_chk(OFS_RX_WORD, x, "frame word");
    end
    rd_chk(OFS_RX_WORD, {16'h0, fr[n], fr[n+1]}, "check hi");
    rd_chk(OFS_RX_WORD, {16'h0, fr[n+2], fr[n+3]}, "check lo");
    wr(OFS_COMMAND, {24'h0, CMD_RECEIVE_DONE});
    @(posedge clk);
    rd_chk(OFS_RX_LEN, 32'h0, "space released");
  endtask
  task automatic tx_frame(input int n);
    logic [31:0] x;
    int          m;
    int unsigned f;
    m = (n < 60) ? 60 : n;
    net.tx_q.delete();
    f = net.tx_frames;
    x = 32'h0;
    while (x < 32'(n)) bus(1'b0, OFS_TX_FREE, 32'h0, x);
    for (int i = 0; i < (n + 1) / 2; i++)
      wr(OFS_TX_WORD, {16'h0, 8'(2*i+1), (2*i+1 < n) ? 8'(2*i+2) : 8'h00});
    wr(OFS_TX_LEN, 32'(n));
    wr(OFS_COMMAND, {24'h0, CMD_SEND});
    @(posedge clk);
    x = 32'h1;
    while (x[0] !== 1'b0) bus(1'b0, OFS_COMMAND, 32'h0, x);
    chk(32'(net.tx_q.size()), 32'(m), "frame size");
    chk(net.tx_frames, f + 1, "last flag");
    for (int i = 0; i < m; i++)
      chk({24'h0, net.tx_q[i]}, (i < n) ? 32'(i+1) : 32'h0, "tx byte");
    rd_chk(OFS_STATE, {24'h0, STATE_RAW_FRAME_OPEN}, "no timeout");
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    test_done;
  end
  initial begin
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rd_chk(OFS_MODE, 32'h0, "mode reset");
    rd_chk(OFS_RX_CFG, 32'h4, "rx size");
    wr(OFS_COMMAND, {24'h0, CMD_OPEN});
    @(posedge clk);
    rd_chk(OFS_STATE, {24'h0, STATE_SHUT}, "open refused");
    rd_chk(8'hFC, 32'h0, "unmapped");
    $display("test reset done");
    wr(OFS_MAC_HI, {16'h0, OWN_MAC[47:32]});
    wr(OFS_MAC_LO, OWN_MAC[31:0]);
    open_raw(8'h44);
    mk(OTHER_MAC, 61);
    rd_chk(OFS_RX_LEN, 32'h0, "foreign dropped");
    mk(OWN_MAC, 61);
    rd_chk(OFS_RX_LEN, 32'd68, "record size");
    drain(61);
    $display("test filter done");
    wr(OFS_COMMAND, {24'h0, CMD_CLOSE});
    @(posedge clk);
    rd_chk(OFS_STATE, {24'h0, STATE_SHUT}, "closed");
    open_raw(8'h04);
    mk(OTHER_MAC, 60);
    rd_chk(OFS_RX_LEN, 32'd66, "record size even");
    drain(60);
    $display("test unfiltered done");
    tx_frame(3);
    tx_frame(62);
    $display("test transmit done");
    test_done;
  end
endmodule
